// ==== logic/ibc_host.sv ====
// ibc_host: host controller that tracks every bank, checks each requested
// command against its target bank state, or all bank states for all-bank commands, and drives legal commands to the memory.
// assumes: link clock arrives as a pin and is sampled here; memory captures
// one command per link clock rising edge; cke is held high by this block.
// Notes on behaviour
// - keep activate-to-activate spacing and at most four activates per window.
// - precharge targets one bank or all; all-bank needs every bank prechargeable.
// - during a mode read from idle only no-operations go out until done.
// - mode write lasts its delay, only no-operations meanwhile, then idle.
// - refresh and mode write go out only when every bank is idle.
// - a write after a read waits for the full read burst.
// - a read after a write waits for the full write burst.
// - after an auto-precharge access other banks take valid commands.
// - reset is a mode write, allowed from power-on or else with all banks idle.
// - commands go out only with enable high twice and exit delay met.
// - any state and command pair not allowed is refused, never sent.
// - mask low writes the data beat, mask high inhibits it.
// - only no-operations to a bank busy with auto-precharge bursts.
`timescale 1ns/1ps
`default_nettype none
module ibc_host
  import ibc_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          link_clk,
  input  wire logic                          req_valid,
  input  wire ibc_pkg::ibc_cmd_e             req_cmd,
  input  wire logic [ibc_pkg::BANK_W-1:0]    req_bank,
  input  wire logic [ibc_pkg::ROW_W-1:0]     req_addr,
  input  wire logic                          req_auto_pre,
  input  wire logic [ibc_pkg::DATA_W-1:0]    wr_data,
  input  wire logic [ibc_pkg::MASK_W-1:0]    wr_mask,
  output logic                               req_ready,
  output logic                               req_refused,
  output logic                               wr_beat_take,
  output logic                               mem_cke,
  output logic                               mem_cs_n,
  output ibc_pkg::ibc_cmd_e                  cmd_code,
  output logic [ibc_pkg::BANK_W-1:0]         cmd_bank,
  output logic [ibc_pkg::ROW_W-1:0]          cmd_addr,
  output logic                               cmd_auto_pre,
  output logic [ibc_pkg::DATA_W-1:0]         dq_out,
  output logic                               dq_oe,
  output logic [ibc_pkg::MASK_W-1:0]         write_byte_mask
);
  import ibc_pkg::*;

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                     lk_sync;
    logic                           lk_prev;
    ibc_bank_e [NUM_BANKS-1:0]      bank;
    logic [NUM_BANKS-1:0][CNT_W-1:0] tmr;
    logic [CNT_W-1:0]               rrd;
    logic [3:0][CNT_W-1:0]          faw;
    logic [CNT_W-1:0]               exit_cnt;
    logic                           dev_busy;
    logic [CNT_W-1:0]               dev_tmr;
    logic                           refused;
    ibc_cmd_e                       code;
    logic [BANK_W-1:0]              bank_o;
    logic [ROW_W-1:0]               addr;
    logic                           ap;
    logic                           cs_n;
    logic [CNT_W-1:0]               beats;
    logic [DATA_W-1:0]              dq;
    logic                           oe;
    logic                           wr;
    logic [MASK_W-1:0]              mask;
  } ibc_state_s;

  ibc_state_s s_q, s_d;

  logic link_rise;
  logic legal;
  logic all_idle;
  logic all_pre_ok;
  logic faw_free;
  logic bursting;

  // link clock edge, read from the second sync stage only
  assign link_rise = s_q.lk_sync[1] & ~s_q.lk_prev;

  // ---------------------------------------------------------------
  // whole-device checks across all bank trackers
  // ---------------------------------------------------------------
  always_comb begin
    all_idle   = 1'b1;
    all_pre_ok = 1'b1;
    bursting   = 1'b0;
    faw_free   = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (s_q.bank[i] != BK_IDLE)
        all_idle = 1'b0;
      if (!(s_q.bank[i] inside {BK_IDLE, BK_ACTIVE, BK_PRECHG}))
        all_pre_ok = 1'b0;
      if (s_q.bank[i] inside {BK_READING, BK_WRITING, BK_RD_AP, BK_WR_AP})
        bursting = 1'b1;
    end
    for (int k = 0; k < 4; k++) begin
      if (s_q.faw[k] == '0)
        faw_free = 1'b1;
    end
  end

  // legality of the requested command against the target tracker, or every tracker for all-bank commands
  always_comb begin
    legal = 1'b0;
    // per-bank commands check the target bank's tracker, all-bank ones check every tracker
    case (req_cmd)
      IBC_NOP:   legal = 1'b1;
      IBC_ACT:   legal = s_q.bank[req_bank] == BK_IDLE && s_q.rrd == '0 && faw_free;
      IBC_RD, IBC_WR:
        // no bank may have burst beats still pending on the shared counter
        legal = s_q.bank[req_bank] == BK_ACTIVE && s_q.beats == '0;
      IBC_PRE:   legal = s_q.bank[req_bank] inside {BK_IDLE, BK_ACTIVE};
      IBC_PREA:  legal = all_pre_ok;
      IBC_MRR:   legal = s_q.bank[req_bank] inside
                   {BK_IDLE, BK_ACTIVE, BK_ACTING, BK_PRECHG, BK_RESET};
      IBC_MRW, IBC_REF: legal = all_idle && !bursting;
      IBC_RESET: legal = s_q.bank[0] == BK_POWERON || (all_idle && !bursting);
      default:   legal = 1'b0;
    endcase
    // device-wide quiet periods and exit delay
    if (s_q.dev_busy || s_q.exit_cnt != '0)
      legal = 1'b0;
    // bank in auto-precharge burst takes nothing
    if (s_q.bank[req_bank] inside {BK_RD_AP, BK_WR_AP, BK_MRR_IDLE, BK_MRR_ACT, BK_MRW})
      legal = 1'b0;
  end

  assign req_ready    = link_rise;
  assign req_refused  = s_q.refused;
  assign wr_beat_take = link_rise && s_q.beats != '0 && s_q.wr;
  assign mem_cke      = 1'b1; // held high so both samples are high
  assign mem_cs_n     = s_q.cs_n;
  assign cmd_code     = s_q.code;
  assign cmd_bank     = s_q.bank_o;
  assign cmd_addr     = s_q.addr;
  assign cmd_auto_pre = s_q.ap;
  assign dq_out       = s_q.dq;
  assign dq_oe        = s_q.oe;
  assign write_byte_mask = s_q.mask;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.lk_sync = {s_q.lk_sync[0], link_clk};
    s_d.lk_prev = s_q.lk_sync[1];
    s_d.refused = 1'b0;
    if (link_rise) begin
      // timers run in link cycles
      if (s_q.rrd != '0) s_d.rrd = s_q.rrd - 1'b1;
      if (s_q.exit_cnt != '0) s_d.exit_cnt = s_q.exit_cnt - 1'b1;
      for (int k = 0; k < 4; k++)
        if (s_q.faw[k] != '0) s_d.faw[k] = s_q.faw[k] - 1'b1;
      if (s_q.dev_tmr != '0) s_d.dev_tmr = s_q.dev_tmr - 1'b1;
      else s_d.dev_busy = 1'b0;
      // per-bank timeouts
      for (int i = 0; i < NUM_BANKS; i++) begin
        if (s_q.tmr[i] != '0) s_d.tmr[i] = s_q.tmr[i] - 1'b1;
        else begin
          case (s_q.bank[i])
            BK_ACTING, BK_MRR_ACT:          s_d.bank[i] = BK_ACTIVE;
            BK_READING, BK_WRITING:         s_d.bank[i] = BK_ACTIVE;
            BK_PRECHG, BK_RD_AP, BK_WR_AP:  s_d.bank[i] = BK_IDLE;
            BK_MRR_IDLE, BK_MRW, BK_REFRESH: s_d.bank[i] = BK_IDLE;
            BK_MRR_RST:                     s_d.bank[i] = BK_RESET;
            BK_RESET:                       s_d.bank[i] = BK_IDLE;
            default:                        s_d.bank[i] = s_q.bank[i];
          endcase
        end
      end
      // write beats with their mask
      if (s_q.beats != '0) begin
        s_d.beats = s_q.beats - 1'b1;
        s_d.oe    = s_q.wr; // enable only with a real beat on the pins
        s_d.dq    = s_q.wr ? wr_data : '0;
        s_d.mask  = s_q.wr ? wr_mask : '0;
      end else begin
        s_d.oe   = 1'b0;
        s_d.wr   = 1'b0;
        s_d.mask = '0;
      end
      s_d.code   = IBC_NOP;
      s_d.cs_n   = 1'b1;
      if (req_valid && req_cmd != IBC_NOP) begin
        if (!legal) s_d.refused = 1'b1;
        else begin
          s_d.code   = req_cmd;
          s_d.cs_n   = 1'b0;
          s_d.bank_o = req_bank;
          s_d.addr   = req_addr;
          s_d.ap     = req_auto_pre;
          case (req_cmd)
            IBC_ACT: begin
              s_d.bank[req_bank] = BK_ACTING;
              s_d.tmr[req_bank]  = ROW_TO_COL_CYC;
              s_d.rrd            = ACT_TO_ACT_CYC;
              s_d.faw = {s_q.faw[2:0], FOUR_ACT_CYC};
            end
            IBC_RD, IBC_WR: begin
              s_d.bank[req_bank] = req_cmd == IBC_RD ?
                (req_auto_pre ? BK_RD_AP : BK_READING) :
                (req_auto_pre ? BK_WR_AP : BK_WRITING);
              s_d.tmr[req_bank] = req_auto_pre ? BURST_CYC + PRECHARGE_CYC : BURST_CYC;
              s_d.beats = BEATS_CNT;
              s_d.wr    = req_cmd == IBC_WR;
            end
            IBC_PRE: begin
              s_d.bank[req_bank] = BK_PRECHG;
              s_d.tmr[req_bank]  = PRECHARGE_CYC;
            end
            IBC_PREA:
              for (int i = 0; i < NUM_BANKS; i++) begin
                s_d.bank[i] = BK_PRECHG;
                s_d.tmr[i]  = PRECHARGE_CYC;
              end
            IBC_MRR: begin
              // timing banks keep their own delay
              if (s_q.bank[req_bank] == BK_IDLE) s_d.bank[req_bank] = BK_MRR_IDLE;
              if (s_q.bank[req_bank] == BK_ACTIVE) s_d.bank[req_bank] = BK_MRR_ACT;
              if (s_q.bank[req_bank] == BK_RESET) s_d.bank[req_bank] = BK_MRR_RST;
              if (!(s_q.bank[req_bank] inside {BK_ACTING, BK_PRECHG}))
                s_d.tmr[req_bank] = MODE_READ_CYC;
              s_d.dev_busy = 1'b1;
              s_d.dev_tmr  = MODE_READ_CYC;
            end
            default: begin
              // refresh, mode write and reset hit every bank
              for (int i = 0; i < NUM_BANKS; i++) begin
                s_d.bank[i] = req_cmd == IBC_REF ? BK_REFRESH :
                              req_cmd == IBC_MRW ? BK_MRW : BK_RESET;
                s_d.tmr[i]  = req_cmd == IBC_REF ? REFRESH_CYC : MODE_WRITE_CYC;
              end
              s_d.dev_busy = 1'b1;
              s_d.dev_tmr  = req_cmd == IBC_REF ? REFRESH_CYC : MODE_WRITE_CYC;
            end
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q          <= '0;
      s_q.bank     <= {NUM_BANKS{BK_POWERON}};
      s_q.exit_cnt <= EXIT_CYC;
      s_q.cs_n     <= 1'b1;
      s_q.code     <= IBC_NOP;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ==== logic/ibc_pkg.sv ====
// ibc_pkg: constants, command codes and bank states for the
// inter-bank command legality host controller.
// assumes: 100 MHz system clock, eight banks, burst length eight.
package ibc_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_BANKS  = 8;
  localparam int unsigned BANK_W     = 3;
  localparam int unsigned ROW_W      = 14;
  localparam int unsigned COL_W      = 10;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned MASK_W     = 2;
  localparam int unsigned BEATS      = 8;
  localparam int unsigned CNT_W      = 8;
  // ---------------------------------------------------------------
  // timing in ns and derived cycle counts (least times round up)
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned ACT_TO_ACT_NS     = 10;
  localparam int unsigned FOUR_ACT_WIN_NS   = 50;
  localparam int unsigned ROW_TO_COL_NS     = 18;
  localparam int unsigned PRECHARGE_NS      = 21;
  localparam int unsigned MODE_READ_NS      = 40;
  localparam int unsigned MODE_WRITE_NS     = 100;
  localparam int unsigned REFRESH_NS        = 130;
  localparam int unsigned BURST_NS          = 80;
  localparam int unsigned EXIT_NS           = 140;
  localparam logic [CNT_W-1:0] ACT_TO_ACT_CYC =
    CNT_W'((ACT_TO_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FOUR_ACT_CYC =
    CNT_W'((FOUR_ACT_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ROW_TO_COL_CYC =
    CNT_W'((ROW_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PRECHARGE_CYC =
    CNT_W'((PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MODE_READ_CYC =
    CNT_W'((MODE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MODE_WRITE_CYC =
    CNT_W'((MODE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] REFRESH_CYC =
    CNT_W'((REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BURST_CYC =
    CNT_W'((BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] EXIT_CYC =
    CNT_W'((EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BEATS_CNT = CNT_W'(BEATS);
  // ---------------------------------------------------------------
  // user request codes (also driven on cmd_code pins)
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    IBC_NOP   = 4'h0,
    IBC_ACT   = 4'h1,
    IBC_RD    = 4'h2,
    IBC_WR    = 4'h3,
    IBC_PRE   = 4'h4,
    IBC_PREA  = 4'h5,
    IBC_MRR   = 4'h6,
    IBC_MRW   = 4'h7,
    IBC_REF   = 4'h8,
    IBC_RESET = 4'h9
  } ibc_cmd_e;
  // ---------------------------------------------------------------
  // per-bank tracked state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    BK_IDLE     = 4'h0,
    BK_ACTING   = 4'h1,
    BK_ACTIVE   = 4'h2,
    BK_READING  = 4'h3,
    BK_WRITING  = 4'h4,
    BK_RD_AP    = 4'h5,
    BK_WR_AP    = 4'h6,
    BK_PRECHG   = 4'h7,
    BK_MRR_IDLE = 4'h8,
    BK_MRR_ACT  = 4'h9,
    BK_MRW      = 4'ha,
    BK_REFRESH  = 4'hb,
    BK_RESET    = 4'hc,
    BK_MRR_RST  = 4'hd,
    BK_POWERON  = 4'he
  } ibc_bank_e;
endpackage

// ==== tb/ibc_host_assertions.sv ====
// ibc_host_assertions: port-level timing checks of the host controller.
// assumes: bound into ibc_host from the bench top; one clk domain.
`timescale 1ns/1ps
`default_nettype none
module ibc_host_chk
  import ibc_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       req_valid,
  input wire logic                       req_ready,
  input wire logic                       req_refused,
  input wire logic                       wr_beat_take,
  input wire logic [ibc_pkg::DATA_W-1:0] wr_data,
  input wire logic [ibc_pkg::MASK_W-1:0] wr_mask,
  input wire logic                       mem_cke,
  input wire logic                       mem_cs_n,
  input wire ibc_pkg::ibc_cmd_e          cmd_code,
  input wire logic [ibc_pkg::BANK_W-1:0] cmd_bank,
  input wire logic [ibc_pkg::DATA_W-1:0] dq_out,
  input wire logic                       dq_oe,
  input wire logic [ibc_pkg::MASK_W-1:0] write_byte_mask
);
  // ----------------------------------------
  // link edges since the last mode read
  // ----------------------------------------
  logic [7:0] mrr_cnt_q;
  logic       mrr_seen_q;
  logic       rdy_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // restart on a mode read going out, else count link edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mrr_cnt_q  <= 8'h00;
      mrr_seen_q <= 1'b0;
      rdy_q      <= 1'b0;
    end else begin
      // a fresh command stands one cycle after a take, back to back too
      rdy_q <= req_ready;
      if (!mem_cs_n && rdy_q && cmd_code == IBC_MRR) begin
        mrr_cnt_q  <= 8'h00;
        mrr_seen_q <= 1'b1;
      end else if (req_ready && mrr_cnt_q != 8'hff) begin
        mrr_cnt_q  <= mrr_cnt_q + 8'h01;
      end
    end
  end
  property p_cke_high; mem_cke; endproperty
  a_cke_high: assert property (p_cke_high) else $error("clock enable low");
  property p_issue_cause; $fell(mem_cs_n) |-> $past(req_valid) && cmd_code != IBC_NOP;
  endproperty
  a_issue_cause: assert property (p_issue_cause) else $error("command without request");
  property p_nop_idle; req_ready && !req_valid |=> ##1 mem_cs_n && cmd_code == IBC_NOP;
  endproperty
  a_nop_idle: assert property (p_nop_idle) else $error("bus not idle");
  property p_cmd_stands;
    !mem_cs_n && !req_ready |=> !mem_cs_n && $stable(cmd_code) && $stable(cmd_bank);
  endproperty
  a_cmd_stands: assert property (p_cmd_stands) else $error("command moved");
  property p_refused_excl; req_refused |-> mem_cs_n; endproperty
  a_refused_excl: assert property (p_refused_excl) else $error("refused yet sent");
  property p_refused_once; req_refused |=> !req_refused; endproperty
  a_refused_once: assert property (p_refused_once) else $error("refusal too long");
  property p_mask;
    wr_beat_take |=> dq_oe && dq_out == $past(wr_data) && write_byte_mask == $past(wr_mask);
  endproperty
  a_mask: assert property (p_mask) else $error("write beat or mask lost");
  property p_mrr_quiet; !mem_cs_n && rdy_q && mrr_seen_q |-> mrr_cnt_q >= MODE_READ_CYC;
  endproperty
  a_mrr_quiet: assert property (p_mrr_quiet) else $error("command in mode read");
endmodule
`default_nettype wire

// ==== tb/ibc_mem_model.sv ====
// ibc_mem_model: memory device model that checks commands and stores writes.
// assumes: commands and write beats are stable at each link_clk rise.
`timescale 1ns/1ps
`default_nettype none
module ibc_mem_model
  import ibc_pkg::*;
(
  input wire logic                        link_clk,
  input wire logic                        mem_cke,
  input wire logic                        mem_cs_n,
  input wire ibc_pkg::ibc_cmd_e           cmd_code,
  input wire logic [ibc_pkg::BANK_W-1:0]  cmd_bank,
  input wire logic                        cmd_auto_pre,
  input wire logic [ibc_pkg::DATA_W-1:0]  dq_out,
  input wire logic                        dq_oe,
  input wire logic [ibc_pkg::MASK_W-1:0]  write_byte_mask,
  output logic [7:0]                      bad_cnt,
  output logic [7:0]                      beat_cnt,
  output logic [ibc_pkg::DATA_W-1:0]      mem_word
);
  // ----------------------------------------
  // bank tracking and command check
  // ----------------------------------------
  logic [NUM_BANKS-1:0] open_q;
  logic [7:0]           quiet_q;
  logic                 pwr_q;
  logic                 ok;
  initial begin
    bad_cnt = 8'h00;
    beat_cnt = 8'h00;
    mem_word = 16'h0000;
    open_q = '0;
    quiet_q = 8'h00;
    pwr_q = 1'b1;
  end
  // nop or deselect leaves every bank as it is
  always @(posedge link_clk) begin
    if (quiet_q != 8'h00) quiet_q <= quiet_q - 8'h01;
    if (dq_oe === 1'b1) begin
      beat_cnt <= beat_cnt + 8'h01;
      if (!write_byte_mask[0]) mem_word[7:0] <= dq_out[7:0];
      if (!write_byte_mask[1]) mem_word[15:8] <= dq_out[15:8];
    end
    if (mem_cs_n === 1'b0 && cmd_code != IBC_NOP) begin
      ok = mem_cke && quiet_q == 8'h00 && (!pwr_q || cmd_code == IBC_RESET);
      case (cmd_code)
        IBC_ACT: ok &= !open_q[cmd_bank];
        IBC_RD, IBC_WR: ok &= open_q[cmd_bank];
        IBC_MRW, IBC_REF: ok &= open_q == '0;
        IBC_RESET: ok &= pwr_q || open_q == '0;
        default: ;
      endcase
      if (!ok) bad_cnt <= bad_cnt + 8'h01;
      case (cmd_code)
        IBC_ACT: open_q[cmd_bank] <= 1'b1;
        IBC_RD, IBC_WR: if (cmd_auto_pre) open_q[cmd_bank] <= 1'b0;
        IBC_PRE: open_q[cmd_bank] <= 1'b0;
        IBC_PREA: open_q <= '0;
        IBC_MRR: quiet_q <= MODE_READ_CYC - 8'h01;
        IBC_MRW: quiet_q <= MODE_WRITE_CYC - 8'h01;
        IBC_REF: quiet_q <= REFRESH_CYC - 8'h01;
        IBC_RESET: begin
          pwr_q <= 1'b0;
          open_q <= '0;
          quiet_q <= MODE_WRITE_CYC - 8'h01;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// tb: self-checking bench for ibc_host with the memory model.
// assumes: link clock 160 ns made here; inputs change at clk falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ibc_pkg::*;
  logic clk, rst, link_clk, req_valid, req_auto_pre, req_ready, req_refused;
  logic wr_beat_take, mem_cke, mem_cs_n, cmd_auto_pre, dq_oe;
  ibc_cmd_e req_cmd, cmd_code;
  logic [BANK_W-1:0] req_bank, cmd_bank;
  logic [ROW_W-1:0] req_addr, cmd_addr;
  logic [DATA_W-1:0] wr_data, dq_out, mem_word;
  logic [MASK_W-1:0] wr_mask, write_byte_mask;
  logic [7:0] bad_cnt, beat_cnt;
  int num_errors, checks, cyc;
  ibc_host ibc_host_inst (.clk, .rst, .link_clk, .req_valid, .req_cmd, .req_bank,
    .req_addr, .req_auto_pre, .wr_data, .wr_mask, .req_ready, .req_refused,
    .wr_beat_take, .mem_cke, .mem_cs_n, .cmd_code, .cmd_bank, .cmd_addr,
    .cmd_auto_pre, .dq_out, .dq_oe, .write_byte_mask);
  ibc_mem_model ibc_mem_model_inst (.link_clk, .mem_cke, .mem_cs_n, .cmd_code,
    .cmd_bank, .cmd_auto_pre, .dq_out, .dq_oe, .write_byte_mask, .bad_cnt,
    .beat_cnt, .mem_word);
  // ----------------------------------------
  // clocks, timeout and shared tasks
  // ----------------------------------------
  initial begin clk = 1'b0; forever #5 clk = ~clk; end
  initial begin link_clk = 1'b0; forever #80 link_clk = ~link_clk; end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin num_errors++; test_done(); end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // wait k link rises, then settle at a falling clk edge
  task automatic wl(int k);
    repeat (k) @(posedge link_clk);
    @(negedge clk);
  endtask
  // one request: ok says whether it must go out or be refused
  task automatic issue(ibc_cmd_e c, logic [2:0] b, logic ap, logic ok);
    logic rf;
    logic sent;
    int n;
    req_cmd = c; req_bank = b; req_auto_pre = ap; req_valid = 1'b1;
    req_addr = {b, 7'h55, c};
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin @(negedge clk); n++; end
    @(negedge clk);
    req_valid = 1'b0;
    rf = req_refused;
    @(negedge clk);
    rf |= req_refused;
    sent = mem_cs_n === 1'b0 && cmd_code === c && cmd_bank === b &&
           cmd_addr === req_addr && cmd_auto_pre === ap;
    chk("refused", 16'(!ok), 16'(rf));
    chk("sent", 16'(ok), 16'(sent));
  endtask
  // eight beats, last one with the low byte inhibited
  task automatic wr_burst();
    int n;
    for (int i = 0; i < 8; i++) begin
      wr_data = 16'ha0b0 + 16'(i);
      wr_mask = (i == 7) ? 2'b01 : 2'b00;
      n = 0;
      while (wr_beat_take !== 1'b1 && n < 40) begin @(negedge clk); n++; end
      @(negedge clk);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power();
    issue(IBC_ACT, 3'h0, 1'b0, 1'b0);
    wl(16);
    issue(IBC_RESET, 3'h0, 1'b0, 1'b1);
    issue(IBC_ACT, 3'h0, 1'b0, 1'b0);
    wl(11);
    $display("test power done");
  endtask
  task automatic t_banks();
    issue(IBC_ACT, 3'h0, 1'b0, 1'b1);
    issue(IBC_ACT, 3'h1, 1'b0, 1'b0);
    issue(IBC_ACT, 3'h1, 1'b0, 1'b1);
    issue(IBC_MRR, 3'h1, 1'b0, 1'b1);
    issue(IBC_RD, 3'h0, 1'b0, 1'b0);
    wl(5);
    issue(IBC_RD, 3'h0, 1'b0, 1'b1);
    issue(IBC_WR, 3'h1, 1'b0, 1'b0);
    wl(9);
    issue(IBC_WR, 3'h1, 1'b0, 1'b1);
    wr_burst();
    wl(3);
    chk("beats", 16'h0008, 16'(beat_cnt));
    chk("word", 16'ha0b6, mem_word);
    issue(IBC_MRW, 3'h0, 1'b0, 1'b0);
    issue(IBC_PRE, 3'h0, 1'b0, 1'b1);
    issue(IBC_MRR, 3'h0, 1'b0, 1'b1);
    wl(6);
    $display("test banks done");
  endtask
  task automatic t_autopre();
    issue(IBC_ACT, 3'h2, 1'b0, 1'b1);
    wl(4);
    issue(IBC_RD, 3'h2, 1'b1, 1'b1);
    issue(IBC_ACT, 3'h3, 1'b0, 1'b1);
    issue(IBC_RD, 3'h2, 1'b0, 1'b0);
    wl(3);
    issue(IBC_MRR, 3'h3, 1'b0, 1'b1);
    wl(9);
    $display("test autopre done");
  endtask
  task automatic t_allidle();
    issue(IBC_PREA, 3'h0, 1'b0, 1'b1);
    wl(5);
    issue(IBC_MRW, 3'h0, 1'b0, 1'b1);
    issue(IBC_REF, 3'h0, 1'b0, 1'b0);
    wl(11);
    issue(IBC_REF, 3'h0, 1'b0, 1'b1);
    wl(14);
    chk("illegal", 16'h0000, 16'(bad_cnt));
    $display("test allidle done");
  endtask
  initial begin
    rst = 1'b1; req_valid = 1'b0; req_cmd = IBC_NOP; req_bank = '0;
    req_addr = '0; req_auto_pre = 1'b0; wr_data = '0; wr_mask = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_power();
    t_banks();
    t_autopre();
    t_allidle();
    test_done();
  end
endmodule
bind ibc_host ibc_host_chk ibc_host_chk_inst (.clk, .rst, .req_valid, .req_ready,
  .req_refused, .wr_beat_take, .wr_data, .wr_mask, .mem_cke, .mem_cs_n, .cmd_code,
  .cmd_bank, .dq_out, .dq_oe, .write_byte_mask);
`default_nettype wire
